// [sar_fifo.sv]
// Function
// - Busy falls promptly after the convert strobe.
// - Busy stays low throughout the conversion.
// - Busy rises after result reaches shift register.
// - Busy low time at most 2.2 us (110 enabled cycles); a pending link transfer in external mode delays the load.
// - Busy rises shortly after conversion ends.
// - Internal data clock period about 110 ns.
// - First internal clock pulse 270 ns after strobe.
// - Chip select low, strobe fall starts conversion.
// - Internal mode sends sixteen pulses, clock idles low.
// - External mode trigger gives sync and sends data.
// - Chip select and strobe are ORed together.
`timescale 1ns/1ns
`default_nettype none

package sar_pkg;
	localparam int CLK_PERIOD_NS    = 20;
	localparam int WORD_BITS        = 16;
	localparam int FIFO_DEPTH       = 8;
	localparam int SYNC_RESET       = 4'h3;
	localparam int T_BUSY_FALL_NS   = 20;
	localparam int BUSY_FALL_CYC    = (T_BUSY_FALL_NS / CLK_PERIOD_NS < 1) ?
		1 : T_BUSY_FALL_NS / CLK_PERIOD_NS;
	localparam int T_CONV_NS        = 2200;
	localparam int CONV_CYC         = T_CONV_NS / CLK_PERIOD_NS;
	localparam int T_BUSY_RISE_NS   = 5;
	localparam int BUSY_RISE_CYC    =
		(T_BUSY_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_DCLK_PERIOD_NS = 110;
	localparam int DCLK_HALF_CYC    =
		(T_DCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam int T_DCLK_FIRST_NS  = 270;
	localparam int DCLK_FIRST_CYC   = T_DCLK_FIRST_NS / CLK_PERIOD_NS;
	// Pipeline of two cycles between start and the clock pin
	localparam int DCLK_WAIT_CYC    = DCLK_FIRST_CYC - DCLK_HALF_CYC - 2;
	// Push and load each take one cycle of the busy-low window
	localparam int CONV_RUN_CYC     = CONV_CYC - 2;
	localparam logic [6:0] CONV_LAST  = 7'(CONV_RUN_CYC - 1);
	localparam logic [3:0] DCLK_WAIT  = 4'(DCLK_WAIT_CYC);
	localparam logic [2:0] DCLK_HALF  = 3'(DCLK_HALF_CYC);
	localparam logic [2:0] DCLK_LAST  = 3'(2 * DCLK_HALF_CYC - 1);
	localparam logic [4:0] BITS_TOTAL = 5'(WORD_BITS);
	localparam int PIN_RC   = 0;
	localparam int PIN_CS   = 1;
	localparam int PIN_MODE = 2;
	localparam int PIN_PD   = 3;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CONV = 4'h2,
		ST_PUSH = 4'h4,
		ST_LOAD = 4'h8
	} sar_state_t;
endpackage

module sar_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic             full;
	logic             empty;

	assign full      = (wr_q[AW] != rd_q[AW]) &&
		(wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty     = (wr_q == rd_q);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_q[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (clk_en && in_valid && !full) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (clk_en) begin
			if (in_valid && !full) begin
				wr_q <= wr_q + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// [sar_conv_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none

module sar_conv_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic        read_conv,
	input  wire logic        chip_sel_n,
	input  wire logic        clock_source_select,
	input  wire logic        power_down_input,
	input  wire logic [15:0] conv_code,
	input  wire logic        serial_data_clock_in,
	output logic             serial_data_clock_out,
	output logic             serial_data_clock_oe,
	output logic             serial_data,
	output logic             sync_pulse,
	output logic             busy_n
);
	logic [3:0]         pin_raw;
	logic [3:0]         pin_s1_q;
	logic [3:0]         pin_s2_q;
	logic               rc_p_q;
	logic               cs_p_q;
	logic               rc_s;
	logic               cs_s;
	logic               mode_ext;
	logic               pd_s;
	logic               strobe_or;
	logic               strobe_or_p;
	logic               conv_go;
	logic               ext_trig;
	sar_pkg::sar_state_t state_q;
	logic [6:0]         conv_cnt_q;
	logic [15:0]        code_q;
	logic [15:0]        prev_q;
	logic               busy_n_q;
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic [15:0]        fifo_out_data;
	logic               load;
	logic               int_active_q;
	logic [3:0]         int_wait_q;
	logic [2:0]         int_ph_q;
	logic [4:0]         int_bits_q;
	logic [15:0]        int_sh_q;
	logic               int_bit_q;
	logic               dclk_out_q;
	logic               dclk_oe_q;
	logic               req_q;
	logic               ack_s1_q;
	logic               ack_s2_q;
	logic               xfer_pend;
	logic               req_s1_lq;
	logic               req_s2_lq;
	logic               ack_lq;
	logic [15:0]        ext_sh_lq;
	logic [4:0]         ext_bits_lq;
	logic               ext_bit_lq;
	logic               sync_lq;
	logic [4:0]         pulse_cnt_q;

	assign pin_raw = {power_down_input, clock_source_select,
		chip_sel_n, read_conv};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_s1_q <= 4'(sar_pkg::SYNC_RESET);
			pin_s2_q <= 4'(sar_pkg::SYNC_RESET);
			rc_p_q   <= 1'b1;
			cs_p_q   <= 1'b1;
		end else if (clk_en) begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			rc_p_q   <= pin_s2_q[sar_pkg::PIN_RC];
			cs_p_q   <= pin_s2_q[sar_pkg::PIN_CS];
		end
	end

	assign rc_s        = pin_s2_q[sar_pkg::PIN_RC];
	assign cs_s        = pin_s2_q[sar_pkg::PIN_CS];
	assign mode_ext    = pin_s2_q[sar_pkg::PIN_MODE];
	assign pd_s        = pin_s2_q[sar_pkg::PIN_PD];
	// Either input may be the later one to fall and so qualify
	assign strobe_or   = rc_s | cs_s;
	assign strobe_or_p = rc_p_q | cs_p_q;
	assign conv_go     = strobe_or_p && !strobe_or && !pd_s &&
		(state_q == sar_pkg::ST_IDLE);
	// Rising edge of the term read-high while selected
	assign ext_trig    = mode_ext && rc_s && !cs_s &&
		!(rc_p_q && !cs_p_q) && !xfer_pend;
	assign load        = (state_q == sar_pkg::ST_LOAD) &&
		fifo_out_valid && !int_active_q && !xfer_pend;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q    <= sar_pkg::ST_IDLE;
			conv_cnt_q <= '0;
			code_q     <= '0;
		end else if (clk_en) begin
			unique case (state_q)
				sar_pkg::ST_IDLE: begin
					conv_cnt_q <= '0;
					if (conv_go) begin
						state_q <= sar_pkg::ST_CONV;
					end
				end
				sar_pkg::ST_CONV: begin
					conv_cnt_q <= conv_cnt_q + 7'h01;
					if (conv_cnt_q == sar_pkg::CONV_LAST) begin
						code_q  <= conv_code;
						state_q <= sar_pkg::ST_PUSH;
					end
				end
				sar_pkg::ST_PUSH: begin
					if (fifo_in_ready) begin
						state_q <= sar_pkg::ST_LOAD;
					end
				end
				sar_pkg::ST_LOAD: begin
					if (load) begin
						state_q <= sar_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	sar_fifo #(
		.WIDTH (sar_pkg::WORD_BITS),
		.DEPTH (sar_pkg::FIFO_DEPTH)
	) i_sar_fifo (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.clk_en    (clk_en),
		.in_valid  (state_q == sar_pkg::ST_PUSH),
		.in_ready  (fifo_in_ready),
		.in_data   (code_q),
		.out_valid (fifo_out_valid),
		.out_ready (load),
		.out_data  (fifo_out_data)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_n_q <= 1'b1;
			prev_q   <= '0;
		end else if (clk_en) begin
			if (conv_go) begin
				busy_n_q <= 1'b0;
			end else if (load) begin
				busy_n_q <= 1'b1;
				prev_q   <= fifo_out_data;
			end
		end
	end

	// Internal clock mode: divider-made data clock
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			int_active_q <= 1'b0;
			int_wait_q   <= '0;
			int_ph_q     <= '0;
			int_bits_q   <= '0;
			int_sh_q     <= '0;
			int_bit_q    <= 1'b0;
			dclk_out_q   <= 1'b0;
			dclk_oe_q    <= 1'b0;
		end else if (clk_en) begin
			dclk_oe_q  <= !mode_ext;
			dclk_out_q <= int_active_q && (int_wait_q == 4'h0) &&
				(int_ph_q >= sar_pkg::DCLK_HALF);
			if (conv_go && !mode_ext) begin
				int_active_q <= 1'b1;
				int_wait_q   <= sar_pkg::DCLK_WAIT;
				int_ph_q     <= '0;
				int_bits_q   <= sar_pkg::BITS_TOTAL;
				int_sh_q     <= prev_q;
			end else if (int_active_q) begin
				if (int_wait_q != 4'h0) begin
					int_wait_q <= int_wait_q - 4'h1;
				end else if (int_ph_q == sar_pkg::DCLK_LAST) begin
					int_ph_q   <= '0;
					int_sh_q   <= {int_sh_q[14:0], 1'b0};
					int_bits_q <= int_bits_q - 5'h01;
					if (int_bits_q == 5'h01) begin
						int_active_q <= 1'b0;
					end
				end else begin
					int_ph_q <= int_ph_q + 3'h1;
					if (int_ph_q == 3'h0) begin
						int_bit_q <= int_sh_q[15];
					end
				end
			end
		end
	end

	// External mode: request handshake toward the link domain
	assign xfer_pend = (req_q != ack_s2_q);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			req_q    <= 1'b0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else if (clk_en) begin
			ack_s1_q <= ack_lq;
			ack_s2_q <= ack_s1_q;
			if (ext_trig) begin
				req_q <= !req_q;
			end
		end
	end

	// prev_q is held steady by load while a request is pending
	always_ff @(posedge serial_data_clock_in or posedge rst) begin
		if (rst) begin
			req_s1_lq   <= 1'b0;
			req_s2_lq   <= 1'b0;
			ack_lq      <= 1'b0;
			ext_sh_lq   <= '0;
			ext_bits_lq <= '0;
			ext_bit_lq  <= 1'b0;
			sync_lq     <= 1'b0;
		end else begin
			req_s1_lq <= req_q;
			req_s2_lq <= req_s1_lq;
			sync_lq   <= 1'b0;
			if (req_s2_lq != ack_lq) begin
				ack_lq      <= req_s2_lq;
				sync_lq     <= 1'b1;
				ext_bit_lq  <= prev_q[15];
				ext_sh_lq   <= {prev_q[14:0], 1'b0};
				ext_bits_lq <= sar_pkg::BITS_TOTAL - 5'h01;
			end else if (ext_bits_lq != 5'h00) begin
				ext_bit_lq  <= ext_sh_lq[15];
				ext_sh_lq   <= {ext_sh_lq[14:0], 1'b0};
				ext_bits_lq <= ext_bits_lq - 5'h01;
			end else begin
				ext_bit_lq <= 1'b0;
			end
		end
	end

	assign busy_n                = busy_n_q;
	assign serial_data_clock_out = dclk_out_q;
	assign serial_data_clock_oe  = dclk_oe_q;
	assign sync_pulse            = sync_lq;
	// Mode is static in use; both sources are flops
	assign serial_data           = mode_ext ? ext_bit_lq : int_bit_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pulse_cnt_q <= '0;
		end else if (clk_en) begin
			if (conv_go) begin
				pulse_cnt_q <= '0;
			end else if (int_active_q && int_wait_q == 4'h0 &&
				int_ph_q == sar_pkg::DCLK_HALF) begin
				pulse_cnt_q <= pulse_cnt_q + 5'h01;
			end
		end
	end

	property p_busy_fall;
		@(posedge ref_clk) disable iff (rst)
		conv_go && clk_en |=> !busy_n_q;
	endproperty
	a_busy_fall: assert property (p_busy_fall)
		else $error("busy did not fall after convert strobe");

	property p_busy_low_conv;
		@(posedge ref_clk) disable iff (rst)
		(state_q == sar_pkg::ST_CONV) || (state_q == sar_pkg::ST_PUSH)
		|-> !busy_n_q;
	endproperty
	a_busy_low_conv: assert property (p_busy_low_conv)
		else $error("busy high while conversion runs");

	property p_busy_rise_load;
		@(posedge ref_clk) disable iff (rst)
		$rose(busy_n_q) |-> $past(load) && state_q == sar_pkg::ST_IDLE;
	endproperty
	a_busy_rise_load: assert property (p_busy_rise_load)
		else $error("busy rose before result was loaded");

	property p_busy_max;
		@(posedge ref_clk) disable iff (rst || !clk_en)
		$fell(busy_n_q) && !mode_ext |-> ##[1:110] busy_n_q;
	endproperty
	a_busy_max: assert property (p_busy_max)
		else $error("busy low longer than conversion time");

	property p_busy_rise_fast;
		@(posedge ref_clk) disable iff (rst)
		load && clk_en |=> busy_n_q;
	endproperty
	a_busy_rise_fast: assert property (p_busy_rise_fast)
		else $error("busy late after conversion end");

	property p_dclk_period;
		@(posedge ref_clk) disable iff (rst || !clk_en)
		$rose(dclk_out_q) |-> dclk_out_q[*3] ##1 !dclk_out_q[*3];
	endproperty
	a_dclk_period: assert property (p_dclk_period)
		else $error("internal data clock period wrong");

	property p_first_pulse;
		@(posedge ref_clk) disable iff (rst || !clk_en)
		conv_go && !mode_ext && clk_en |-> !dclk_out_q ##13 $rose(dclk_out_q);
	endproperty
	a_first_pulse: assert property (p_first_pulse)
		else $error("first data clock pulse mistimed");

	property p_pulse_count;
		@(posedge ref_clk) disable iff (rst)
		$fell(int_active_q) |-> pulse_cnt_q == 5'h10 ##1 !dclk_out_q[*4];
	endproperty
	a_pulse_count: assert property (p_pulse_count)
		else $error("internal frame did not give sixteen pulses");

	property p_conv_start;
		@(posedge ref_clk) disable iff (rst)
		$fell(strobe_or) && !pd_s && clk_en &&
		state_q == sar_pkg::ST_IDLE |=> state_q == sar_pkg::ST_CONV;
	endproperty
	a_conv_start: assert property (p_conv_start)
		else $error("conversion not started by qualified strobe");

	property p_sync_one;
		@(posedge serial_data_clock_in) disable iff (rst)
		sync_lq |-> ext_bits_lq == 5'h0F ##1 !sync_lq;
	endproperty
	a_sync_one: assert property (p_sync_one)
		else $error("sync pulse not a single clock at frame start");
endmodule

`default_nettype wire

// [sar_host_model.sv]
`timescale 1ns/1ns
`default_nettype none

module sar_host_model (
	input  wire logic        run,
	input  wire logic        serial_data,
	input  wire logic        sync_pulse,
	output logic             serial_data_clock_in,
	output logic [15:0]      word,
	output logic [7:0]       sync_cnt
);
	logic        clk_q = 1'b0;
	logic [15:0] word_q = 16'h0000;
	logic [7:0]  cnt_q = 8'h00;
	logic [4:0]  left_q = 5'h00;

	assign serial_data_clock_in = clk_q;
	assign word = word_q;
	assign sync_cnt = cnt_q;

	// 64 ns period, 32 ns phases; the clock idles low outside a frame
	always begin
		#32;
		clk_q = run ? ~clk_q : 1'b0;
	end

	// Sync marks the first bit; fifteen more follow, MSB first
	always @(posedge clk_q) begin
		if (sync_pulse === 1'b1) begin
			cnt_q <= cnt_q + 8'h01;
			word_q <= {word_q[14:0], serial_data};
			left_q <= 5'h0F;
		end else if (left_q != 5'h00) begin
			word_q <= {word_q[14:0], serial_data};
			left_q <= left_q - 5'h01;
		end
	end
endmodule

`default_nettype wire

// [sar_conv_ctrl_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module sar_conv_ctrl_tb;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b0;
	logic        clk_en = 1'b1;
	logic        read_conv = 1'b1;
	logic        chip_sel_n = 1'b0;
	logic        mode = 1'b0;
	logic        pwr_dn = 1'b0;
	logic [15:0] conv_code = 16'h0000;
	logic        run = 1'b0;
	logic        sclk_in;
	logic        sclk_out;
	logic        sclk_oe;
	logic        sdata;
	logic        sync;
	logic        busy_n;
	logic [15:0] host_word;
	logic [7:0]  sync_cnt;
	int          error_cnt = 0;
	int          comparisons = 0;

	always #10 ref_clk = ~ref_clk;

	sar_conv_ctrl i_sar_conv_ctrl (
		.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
		.read_conv(read_conv), .chip_sel_n(chip_sel_n),
		.clock_source_select(mode), .power_down_input(pwr_dn),
		.conv_code(conv_code), .serial_data_clock_in(sclk_in),
		.serial_data_clock_out(sclk_out), .serial_data_clock_oe(sclk_oe),
		.serial_data(sdata), .sync_pulse(sync), .busy_n(busy_n)
	);

	sar_host_model i_sar_host_model (
		.run(run), .serial_data(sdata), .sync_pulse(sync),
		.serial_data_clock_in(sclk_in), .word(host_word),
		.sync_cnt(sync_cnt)
	);

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Strobe, then follow busy and the internal clock until busy rises
	task automatic convert(input logic [15:0] code, input logic by_cs,
		input logic [15:0] exp, input logic chk);
		int n;
		int low;
		int first;
		int last;
		int per;
		int pulses;
		logic prev;
		logic [15:0] w;
		n = 0;
		low = 0;
		first = -1;
		last = 0;
		per = 0;
		pulses = 0;
		prev = 1'b0;
		w = 16'h0000;
		@(posedge ref_clk);
		conv_code <= code;
		if (by_cs) chip_sel_n <= 1'b0; else read_conv <= 1'b0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (busy_n !== 1'b0 && n < 10);
		check("busy fall delay", 16'(n <= 5), 16'h0001);
		while (busy_n === 1'b0 && low < 200) begin
			low++;
			if (sclk_out === 1'b1 && prev === 1'b0) begin
				if (first < 0) first = low;
				per = low - last;
				last = low;
				pulses++;
				w = {w[14:0], sdata};
			end
			prev = sclk_out;
			@(posedge ref_clk);
			// A second strobe mid-conversion must be ignored
			if (!mode && !by_cs && low == 30) read_conv <= 1'b1;
			if (!mode && !by_cs && low == 40) read_conv <= 1'b0;
			#1;
		end
		check("busy low cycles", 16'(low), 16'h006E);
		if (!mode) begin
			check("first clock", 16'(first), 16'h000D);
			check("clock period", 16'(per), 16'h0006);
			check("clock pulses", 16'(pulses), 16'h0010);
			check("clock enable", {15'h0000, sclk_oe}, 16'h0001);
			if (chk) check("frame word", w, exp);
		end
	endtask

	task automatic release_rc();
		@(posedge ref_clk);
		read_conv <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask

	// Ten frozen cycles mid-conversion stretch busy by ten cycles
	task automatic freeze_conv();
		int low;
		low = 0;
		@(posedge ref_clk);
		read_conv <= 1'b0;
		repeat (10) @(posedge ref_clk);
		clk_en <= 1'b0;
		repeat (10) @(posedge ref_clk);
		clk_en <= 1'b1;
		#1;
		while (busy_n === 1'b0 && low < 200) begin
			low++;
			@(posedge ref_clk);
			#1;
		end
		check("frozen busy low", 16'(low), 16'h0067);
	endtask

	// Conversion, then a link read after busy rises
	task automatic ext_frame(input logic [15:0] code, input logic by_cs);
		logic [7:0] s0;
		if (by_cs) begin
			@(posedge ref_clk);
			chip_sel_n <= 1'b1;
			repeat (5) @(posedge ref_clk);
			read_conv <= 1'b0;
			repeat (5) @(posedge ref_clk);
		end
		convert(code, by_cs, 16'h0000, 1'b0);
		s0 = sync_cnt;
		@(posedge ref_clk);
		if (by_cs) begin
			chip_sel_n <= 1'b1;
			repeat (5) @(posedge ref_clk);
			read_conv <= 1'b1;
			repeat (5) @(posedge ref_clk);
			chip_sel_n <= 1'b0;
		end else begin
			read_conv <= 1'b1;
		end
		repeat (5) @(posedge ref_clk);
		run <= 1'b1;
		repeat (90) @(posedge ref_clk);
		run <= 1'b0;
		repeat (5) @(posedge ref_clk);
		#1;
		check("link word", host_word, code);
		check("sync count", 16'(sync_cnt - s0), 16'h0001);
		check("clock enable", {15'h0000, sclk_oe}, 16'h0000);
	endtask

	initial begin
		// Edge at time zero so the stopped link domain resets too
		rst <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		check("idle busy", {15'h0000, busy_n}, 16'h0001);
		convert(16'hA5C3, 1'b0, 16'h0000, 1'b0);
		release_rc();
		convert(16'h3C5A, 1'b0, 16'hA5C3, 1'b1);
		release_rc();
		freeze_conv();
		release_rc();
		repeat (20) @(posedge ref_clk);
		#1;
		check("idle clock", {15'h0000, sclk_out}, 16'h0000);
		// Power down holds off a convert strobe
		@(posedge ref_clk);
		pwr_dn <= 1'b1;
		repeat (5) @(posedge ref_clk);
		read_conv <= 1'b0;
		repeat (10) @(posedge ref_clk);
		#1;
		check("busy in power down", {15'h0000, busy_n}, 16'h0001);
		release_rc();
		pwr_dn <= 1'b0;
		mode <= 1'b1;
		repeat (5) @(posedge ref_clk);
		ext_frame(16'h1E87, 1'b0);
		ext_frame(16'h7B12, 1'b1);
		finish_test();
	end

	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end
endmodule

`default_nettype wire
